// [common/acs_cfg.svh]
// Register map, reset values, field masks and scan constants of the
// channel-select and range-select block.
// Assumes inclusion from the package and from the design files only.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// Register offsets on the plain register port
`define ACS_ADDR_PRIMARY 8'h50
`define ACS_ADDR_UPPER 8'h51
`define ACS_ADDR_RANGE 8'h52

// Reset values
`define ACS_RST_PRIMARY 16'h0000
`define ACS_RST_UPPER 16'h0000
`define ACS_RST_RANGE 16'hFFFF

// Writable bits of each select register; all others read as zero
`define ACS_MASK_PRIMARY 16'h7FFF
`define ACS_MASK_UPPER 16'h7000

// Field positions in the primary select register
`define ACS_BIT_SE0 14
`define ACS_BIT_SE1 13
`define ACS_BIT_PAIR_A 12
`define ACS_BIT_SE2 11
`define ACS_BIT_SE3 10
`define ACS_BIT_PAIR_B 9

// Scan slots: fifteen in the primary register, three in the upper one
`define ACS_SLOTS 18
`define ACS_SLOTS_PRIMARY 15
`define ACS_SLOT_PAIR_A 2
`define ACS_SLOT_PAIR_B 5
`define ACS_SLOT_SE4 6
`define ACS_FIRST_SE4_CH 4
`define ACS_FIRST_SE13_CH 13

`endif

// [common/acs_pkg.sv]
// Types shared by the channel-select and range-select block.
// Assumes the constants header sits beside it on the include path.
`include "acs_cfg.svh"

package acs_pkg;

    // One register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } acs_bus_req_s;

    // One conversion handed to the sequencer
    typedef struct packed {
        logic [3:0] channel;      // Input converted, also the data register index
        logic diff;               // Pair conversion with this channel positive
        logic twos;               // Result coded as two's complement
        logic range_double;       // Range of twice the reference
    } acs_conv_s;

    // Scan control states
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_LOAD,
        ACS_ISSUE
    } acs_state_e;

endpackage

// [design/acs_scan_ctrl.sv]
// Channel-select, range-select registers and the scan walker of a
// multichannel monitoring converter.
// Assumes a register master and a conversion sequencer on clk_sys.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

`include "acs_cfg.svh"

module acs_scan_ctrl
    import acs_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Scan control from the sequencer
    input wire logic scan_start,
    output logic scan_busy,
    output logic scan_done,
    // Conversion handshake
    output logic conv_valid,
    input wire logic conv_ready,
    output acs_conv_s conv,
    // Per-channel range select to the front end, index is channel
    output logic [15:0] range_double_bit
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    acs_bus_req_s req;                         // Bundled register request
    logic [15:0] scan_select_primary_reg;      // Primary select
    logic [15:0] scan_select_primary_next;
    logic [15:0] scan_select_upper_reg;        // Upper select
    logic [15:0] scan_select_upper_next;
    logic [15:0] input_range_select_reg;       // Range bits, input 0 at top
    logic [15:0] input_range_select_next;
    logic [15:0] rdata_reg;                    // Read data, one cycle late
    logic [15:0] rdata_next;
    acs_state_e state_reg;                     // Scan state
    acs_state_e state_next;
    logic [`ACS_SLOTS-1:0] pending_reg;        // Slots still to visit
    logic [`ACS_SLOTS-1:0] pending_next;
    acs_conv_s conv_reg;                       // Conversion on offer
    acs_conv_s conv_next;
    logic done_reg;                            // End of scan pulse
    logic done_next;
    logic [`ACS_SLOTS-1:0] slot_en;            // Live slot enables
    logic pick_found;                          // A slot is pending
    logic [4:0] pick_idx;                      // First pending slot
    acs_conv_s pick_conv;                      // Its conversion

    ////////////////////////////////////////////////////////////////////////
    // Slot number to channel number
    function automatic logic [3:0] slot_channel(input logic [4:0] slot);
        logic [3:0] ch;
        ch = 4'h0;
        if (slot == 5'd0 || slot == 5'd2) begin
            ch = 4'h0;
        end else if (slot == 5'd1) begin
            ch = 4'h1;
        end else if (slot == 5'd3 || slot == 5'd5) begin
            ch = 4'h2;
        end else if (slot == 5'd4) begin
            ch = 4'h3;
        end else if (slot < 5'(`ACS_SLOTS_PRIMARY)) begin
            // Bits 8..0 are inputs 4..12
            ch = 4'(slot - 5'(`ACS_SLOT_SE4) + 5'(`ACS_FIRST_SE4_CH));
        end else begin
            // Upper bits are inputs 13..15
            ch = 4'(slot - 5'(`ACS_SLOTS_PRIMARY) + 5'(`ACS_FIRST_SE13_CH));
        end
        return ch;
    endfunction

    // Slot number to pair flag
    function automatic logic slot_is_pair(input logic [4:0] slot);
        return (slot == 5'(`ACS_SLOT_PAIR_A)) || (slot == 5'(`ACS_SLOT_PAIR_B));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Submodules
    acs_slot_map u_map (
        .primary(scan_select_primary_reg),
        .upper(scan_select_upper_reg),
        .slot_en(slot_en)
    );

    acs_slot_pick u_pick (
        .pending(pending_reg),
        .found(pick_found),
        .idx(pick_idx)
    );

    ////////////////////////////////////////////////////////////////////////
    // Range bits reordered by channel for the front end
    genvar gc;
    generate
        for (gc = 0; gc < 16; gc++) begin : g_rng
            assign range_double_bit[gc] = input_range_select_reg[15-gc];
        end
    endgenerate

    // Conversion for the first pending slot
    always_comb begin
        pick_conv.channel = slot_channel(pick_idx);
        // Pair results in two's complement, single-ended in binary
        pick_conv.diff = slot_is_pair(pick_idx);
        pick_conv.twos = slot_is_pair(pick_idx);
        // A pair takes the range bit of its positive input
        pick_conv.range_double = range_double_bit[pick_conv.channel];
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file next values
    always_comb begin
        req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
        scan_select_primary_next = scan_select_primary_reg;
        scan_select_upper_next = scan_select_upper_reg;
        input_range_select_next = input_range_select_reg;
        rdata_next = 16'h0000;
        if (req.wr) begin
            unique case (req.addr)
                // Top bit never takes a write
                `ACS_ADDR_PRIMARY: begin
                    scan_select_primary_next = req.wdata & `ACS_MASK_PRIMARY;
                end
                // Only bits 14..12 are kept
                `ACS_ADDR_UPPER: begin
                    scan_select_upper_next = req.wdata & `ACS_MASK_UPPER;
                end
                // Every range bit is read/write
                `ACS_ADDR_RANGE: begin
                    input_range_select_next = req.wdata;
                end
                // Unmapped writes are dropped
                default: begin
                end
            endcase
        end
        if (req.rd) begin
            unique case (req.addr)
                `ACS_ADDR_PRIMARY: rdata_next = scan_select_primary_reg;
                `ACS_ADDR_UPPER: rdata_next = scan_select_upper_reg;
                `ACS_ADDR_RANGE: rdata_next = input_range_select_reg;
                // Unmapped reads return zero
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scan_select_primary_reg <= `ACS_RST_PRIMARY;
            scan_select_upper_reg <= `ACS_RST_UPPER;
            input_range_select_reg <= `ACS_RST_RANGE;
            rdata_reg <= 16'h0000;
        end else if (clk_en) begin
            scan_select_primary_reg <= scan_select_primary_next;
            scan_select_upper_reg <= scan_select_upper_next;
            input_range_select_reg <= input_range_select_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Scan walker next values
    always_comb begin
        state_next = state_reg;
        pending_next = pending_reg;
        conv_next = conv_reg;
        done_next = 1'b0;
        unique case (state_reg)
            // Take a snapshot of the enabled slots
            ACS_IDLE: begin
                if (scan_start) begin
                    pending_next = slot_en;
                    state_next = ACS_LOAD;
                end
            end
            // Offer the first pending slot, or end the scan
            ACS_LOAD: begin
                if (pick_found) begin
                    conv_next = pick_conv;
                    pending_next[pick_idx] = 1'b0;
                    state_next = ACS_ISSUE;
                end else begin
                    done_next = 1'b1;
                    state_next = ACS_IDLE;
                end
            end
            // Hold the offer until the sequencer takes it
            ACS_ISSUE: begin
                if (conv_ready) begin
                    state_next = ACS_LOAD;
                end
            end
        endcase
    end

    // Scan walker flops
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ACS_IDLE;
            pending_reg <= '0;
            conv_reg <= '0;
            done_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            pending_reg <= pending_next;
            conv_reg <= conv_next;
            done_reg <= done_next;
        end
    end

    // Outputs
    assign conv = conv_reg;
    assign conv_valid = (state_reg == ACS_ISSUE);
    assign scan_busy = (state_reg != ACS_IDLE);
    assign scan_done = done_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // Helper: last slot offered in the current scan
    logic [4:0] last_idx_reg;
    logic first_reg;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            last_idx_reg <= 5'h00;
            first_reg <= 1'b1;
        end else if (clk_en) begin
            if (state_reg == ACS_IDLE) begin
                first_reg <= 1'b1;
            end else if (state_reg == ACS_LOAD && pick_found) begin
                last_idx_reg <= pick_idx;
                first_reg <= 1'b0;
            end
        end
    end

    sequence s_load_slot;
        clk_en && state_reg == ACS_LOAD && pick_found;
    endsequence

    sequence s_offer_held;
        conv_valid && $stable(conv) [*1];
    endsequence

    prim_top_zero_a: assert property (scan_select_primary_reg[15] == 1'b0)
        else $error("primary select top bit is set");

    upper_rest_zero_a: assert property (
        (scan_select_upper_reg & ~`ACS_MASK_UPPER) == 16'h0000)
        else $error("upper select holds a reserved bit");

    scan_snapshot_a: assert property (
        clk_en && state_reg == ACS_IDLE && scan_start |=> pending_reg == $past(slot_en))
        else $error("scan did not capture the enabled slots");

    visit_order_a: assert property (
        (s_load_slot and !first_reg) |-> pick_idx > last_idx_reg)
        else $error("slot offered out of order");

    pair_a_override_a: assert property (
        slot_en[`ACS_SLOT_PAIR_A] |-> !scan_select_primary_reg[`ACS_BIT_SE0]
            && !scan_select_primary_reg[`ACS_BIT_SE1])
        else $error("first pair enabled beside a single-ended select");

    pair_b_override_a: assert property (
        slot_en[`ACS_SLOT_PAIR_B] |-> !scan_select_primary_reg[`ACS_BIT_SE2]
            && !scan_select_primary_reg[`ACS_BIT_SE3])
        else $error("second pair enabled beside a single-ended select");

    format_pair_a: assert property (
        conv_valid |-> conv.twos == conv.diff
            && (!conv.diff || conv.channel == 4'h0 || conv.channel == 4'h2))
        else $error("result format or pair channel wrong");

    offer_hold_a: assert property (
        conv_valid && !conv_ready && clk_en |=> s_offer_held)
        else $error("offer dropped or changed before acceptance");

    // Positive input is channel 0 or 2; its range bit as it stood at the load
    pair_range_a: assert property (
        s_load_slot ##1 conv_valid && conv.diff |->
            conv.range_double == ((conv.channel == 4'h0) ?
                $past(input_range_select_reg[15]) : $past(input_range_select_reg[13])))
        else $error("pair range bit not from positive input");

    range_write_a: assert property (
        clk_en && reg_wr && reg_addr == `ACS_ADDR_RANGE |=>
            range_double_bit[0] == $past(reg_wdata[15])
            && range_double_bit[15] == $past(reg_wdata[0]))
        else $error("range bits not mapped channel 0 at top");

    scan_end_a: assert property (
        clk_en && state_reg == ACS_LOAD && !pick_found |=> scan_done)
        else $error("scan end not flagged");

    // The end flag freezes with clk_en, so it must drop after one enabled edge
    done_pulse_a: assert property (
        scan_done && clk_en |=> !scan_done)
        else $error("scan end flag held too long");

endmodule
`default_nettype wire

// [design/acs_slot_map.sv]
// Turns the two select registers into the enable vector of the scan
// slots, in visit order, with pair conflicts resolved.
// Assumes register contents from the same clock domain.
`timescale 1ns/1ps
`default_nettype none

`include "acs_cfg.svh"

module acs_slot_map
    import acs_pkg::*;
(
    // Select registers
    input wire logic [15:0] primary,
    input wire logic [15:0] upper,
    // Slot enables, slot 0 visited first
    output logic [`ACS_SLOTS-1:0] slot_en
);

    ////////////////////////////////////////////////////////////////////////
    // Primary register bits 14 down to 0 give slots 0 to 14
    genvar gi;
    generate
        for (gi = 0; gi < `ACS_SLOTS_PRIMARY; gi++) begin : g_prim
            if (gi == `ACS_SLOT_PAIR_A) begin : g_pa
                // Pair used only with both single-ended bits clear
                assign slot_en[gi] = primary[`ACS_BIT_PAIR_A]
                    & ~primary[`ACS_BIT_SE0] & ~primary[`ACS_BIT_SE1];
            end else if (gi == `ACS_SLOT_PAIR_B) begin : g_pb
                // Pair used only with both single-ended bits clear
                assign slot_en[gi] = primary[`ACS_BIT_PAIR_B]
                    & ~primary[`ACS_BIT_SE2] & ~primary[`ACS_BIT_SE3];
            end else begin : g_se
                // Independent single-ended enables
                assign slot_en[gi] = primary[14-gi];
            end
        end
        // Upper register bits 14 down to 12 give slots 15 to 17
        for (gi = `ACS_SLOTS_PRIMARY; gi < `ACS_SLOTS; gi++) begin : g_up
            assign slot_en[gi] = upper[14-(gi-`ACS_SLOTS_PRIMARY)];
        end
    endgenerate

endmodule
`default_nettype wire

// [design/acs_slot_pick.sv]
// Finds the first pending scan slot in visit order.
// Assumes a pending vector from the same clock domain.
`timescale 1ns/1ps
`default_nettype none

`include "acs_cfg.svh"

module acs_slot_pick
    import acs_pkg::*;
(
    // Slots still to visit
    input wire logic [`ACS_SLOTS-1:0] pending,
    // Result
    output logic found,
    output logic [4:0] idx
);

    ////////////////////////////////////////////////////////////////////////
    // Lowest slot number wins, so the scan walks in fixed order
    always_comb begin
        found = 1'b0;
        idx = 5'h00;
        for (int i = `ACS_SLOTS - 1; i >= 0; i--) begin
            if (pending[i]) begin
                found = 1'b1;
                idx = 5'(i);
            end
        end
    end

endmodule
`default_nettype wire

// [testbench/acs_seq_model.sv]
// Conversion sequencer model on the far side of the scan walker.
// Assumes the walker offers conversions on clk_sys with a level valid.
`timescale 1ns/1ps
`default_nettype none

module acs_seq_model
    import acs_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // Offer from the walker
    input wire logic conv_valid,
    // Cycles to stall each offer before taking it
    input wire logic [1:0] stall,
    // Acceptance
    output logic conv_ready
);
    // Stall counter of the current offer
    logic [1:0] wait_reg;

    ////////////////////////////////////////////////////////////////////////
    // Takes each offer after the stall; frozen while clk_en is low
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            conv_ready <= 1'b0;
            wait_reg <= 2'h0;
        end else if (clk_en) begin
            if (conv_valid && conv_ready) begin
                // Offer taken at this edge, let go
                conv_ready <= 1'b0;
                wait_reg <= 2'h0;
            end else if (conv_valid && wait_reg >= stall) begin
                conv_ready <= 1'b1;
            end else if (conv_valid) begin
                wait_reg <= wait_reg + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/adc_channel_sequence_gain_tb.sv]
// Self-checking bench of the channel-select and range-select block.
// Assumes the package, the constants header and the sequencer model.
`timescale 1ns/1ps
`default_nettype none

module adc_channel_sequence_gain_tb;
    import acs_pkg::*;

    // Design signals
    logic clk_sys = 1'b0;
    logic arst_n, reg_wr, reg_rd, scan_start, scan_busy, scan_done;
    logic clk_en = 1'b1;
    logic conv_valid, conv_ready;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, range_double_bit;
    acs_conv_s conv;
    // Bench state
    logic [1:0] stall;
    logic jit = 1'b0;
    logic [15:0] lfsr_q = 16'h0017;
    int miscompares = 0;
    int n_checks = 0;
    acs_conv_s expq[$];
    // Select pairs written before each of the first nine scans
    logic [31:0] cases [9] = '{32'h4100_0000, 32'h1200_0000, 32'h7FFF_7000,
        32'h5000_0000, 32'h2200_0000, 32'h0A00_0000, 32'h0600_0000,
        32'h0000_0000, 32'h0000_FFFF};

    acs_scan_ctrl dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .scan_start(scan_start), .scan_busy(scan_busy),
        .scan_done(scan_done), .conv_valid(conv_valid), .conv_ready(conv_ready),
        .conv(conv), .range_double_bit(range_double_bit));

    acs_seq_model seq_u (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
        .conv_valid(conv_valid), .stall(stall), .conv_ready(conv_ready));

    always #10 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    // Random source; also drops clk_en now and then while a scan runs
    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    always @(posedge clk_sys) begin
        lfsr_q <= lfsr_step(lfsr_q);
        clk_en <= jit ? (lfsr_q[2:0] != 3'h0) : 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and register port tasks
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (!ok) begin
            miscompares++;
            $display("BAD t=%0t %s", $time, msg);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata === exp, "read data");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Expected offers of one scan, in visit order
    task automatic push_c(input int ch, input logic d, input logic [15:0] g);
        acs_conv_s c;
        c = '{channel: ch[3:0], diff: d, twos: d, range_double: g[15-ch]};
        expq.push_back(c);
    endtask

    task automatic expect_scan(input logic [15:0] p, input logic [15:0] u,
                               input logic [15:0] g);
        if (p[14]) push_c(0, 1'b0, g);
        if (p[13]) push_c(1, 1'b0, g);
        if (p[12] && !p[14] && !p[13]) push_c(0, 1'b1, g);
        if (p[11]) push_c(2, 1'b0, g);
        if (p[10]) push_c(3, 1'b0, g);
        if (p[9] && !p[11] && !p[10]) push_c(2, 1'b1, g);
        for (int k = 8; k >= 0; k--) begin
            if (p[k]) push_c(12 - k, 1'b0, g);
        end
        for (int k = 14; k >= 12; k--) begin
            if (u[k]) push_c(27 - k, 1'b0, g);
        end
    endtask

    // Starts a scan, retries the start while busy, waits for the end
    task automatic run_scan();
        int i;
        logic busy_scan;
        busy_scan = (expq.size() != 0);
        @(posedge clk_sys);
        scan_start <= 1'b1;
        @(posedge clk_sys);
        scan_start <= 1'b0;
        @(posedge clk_sys);
        scan_start <= busy_scan;
        jit <= 1'b1;
        @(posedge clk_sys);
        scan_start <= 1'b0;
        for (i = 0; i < 400 && scan_done !== 1'b1; i++) @(posedge clk_sys);
        jit <= 1'b0;
        chk(i < 400, "no scan end");
        repeat (6) @(posedge clk_sys);
        #1;
        chk(expq.size() == 0, "offers missing");
        chk(scan_busy === 1'b0, "still busy");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watches accepted offers against the oldest note
    always @(posedge clk_sys) begin
        if (arst_n && clk_en && conv_valid === 1'b1 && conv_ready === 1'b1) begin
            if (expq.size() == 0) chk(1'b0, "extra conversion");
            else chk(conv === expq.pop_front(), "conversion");
            chk(scan_busy === 1'b1, "not busy during offer");
        end
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        miscompares++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [15:0] p, u, g;
        arst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        scan_start = 1'b0;
        stall = 2'h0;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        reg_read(8'h50, 16'h0000);
        reg_read(8'h51, 16'h0000);
        reg_read(8'h52, 16'hFFFF);
        chk(range_double_bit === 16'hFFFF, "range after reset");
        reg_write(8'h53, 16'hFFFF);
        reg_read(8'h53, 16'h0000);
        reg_read(8'h50, 16'h0000);
        $display("test reset and map done");
        for (int k = 0; k < 13; k++) begin
            p = (k < 9) ? cases[k][31:16] : lfsr_q;
            u = (k < 9) ? cases[k][15:0] : lfsr_step(lfsr_q);
            g = ~lfsr_q ^ {lfsr_q[7:0], lfsr_q[15:8]};
            stall <= lfsr_q[1:0];
            reg_write(8'h50, p);
            reg_write(8'h51, u);
            reg_write(8'h52, g);
            reg_read(8'h50, p & 16'h7FFF);
            reg_read(8'h51, u & 16'h7000);
            reg_read(8'h52, g);
            for (int n = 0; n < 16; n++) begin
                chk(range_double_bit[n] === g[15-n], "range bit");
            end
            expect_scan(p & 16'h7FFF, u & 16'h7000, g);
            run_scan();
            $display("test scan %0d done", k);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
